// [verilog/kpd_pkg.sv]
// shared constants and types of the keypad matrix scanner
package kpd_pkg;
    localparam int COLS = 6;
    localparam int ROWS = 8;
    localparam int DKEYS = 4;
    localparam int DEB_W = ROWS + DKEYS;
    localparam int DEB_CNT_W = 16;
    localparam int ENC_W = 8;
    localparam int ADDR_W = 8;
    localparam int ST_W = 4;

    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DEBOUNCE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_LIVE = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_ENC = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_SCAN_LO = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_SCAN_HI = 8'h1c;

    localparam int CTRL_MS_LSB = 0;
    localparam int CTRL_AUTO_EN = 6;
    localparam int CTRL_SOA_EN = 7;
    localparam int CTRL_IGN_MULTI = 8;
    localparam int CTRL_DIRECT_EN = 9;
    localparam int CTRL_ENC_A_EN = 10;
    localparam int CTRL_ENC_B_EN = 11;
    localparam int CTRL_AUTO_GO = 12;
    localparam int CTRL_W = 12;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
    localparam logic [DEB_CNT_W-1:0] DEB_RESET = 16'h00ff;

    localparam int ST_MATRIX = 0;
    localparam int ST_DIRECT = 1;
    localparam int ST_SCAN = 2;
    localparam int ST_ENC = 3;

    localparam int CLK_MHZ = 125;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_drive = 3'b010,
        st_done = 3'b100
    } kpd_scan_state_t;
endpackage : kpd_pkg

// [verilog/kpd_deb_if.sv]
// debounce carrier between the controller and its input filter
`timescale 1ns/100ps
interface kpd_deb_if;
    logic ce;
    logic [kpd_pkg::DEB_W-1:0] raw;
    logic [kpd_pkg::DEB_CNT_W-1:0] limit;
    logic [kpd_pkg::DEB_W-1:0] stable;
    logic [kpd_pkg::DEB_W-1:0] rose;
    modport owner(output ce, raw, limit, input stable, rose);
    modport filter(input ce, raw, limit, output stable, rose);
endinterface : kpd_deb_if

// [verilog/kpd_debounce.sv]
// debounce filter for matrix returns and direct keys
`timescale 1ns/100ps
module kpd_debounce (
    input wire logic pclk,
    input wire logic presetn,
    kpd_deb_if.filter d
);
    logic [kpd_pkg::DEB_W-1:0] last;
    logic [kpd_pkg::DEB_CNT_W-1:0] cnt;

    // a change only counts once the inputs held still past the limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= '0;
            cnt <= '0;
            d.stable <= '0;
            d.rose <= '0;
        end else if (d.ce) begin
            d.rose <= '0;
            if (d.raw != last) begin
                last <= d.raw;
                cnt <= '0;
            end else if (cnt < d.limit) begin
                cnt <= cnt + 1'b1;
            end else if (d.stable != last) begin
                d.stable <= last;
                d.rose <= last & ~d.stable;
            end
        end
    end
endmodule : kpd_debounce

// [verilog/kpd_encoder.sv]
// quadrature decoder for one rotary encoder
`timescale 1ns/100ps
module kpd_encoder (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic en,
    input wire logic phase_a,
    input wire logic phase_b,
    output logic [kpd_pkg::ENC_W-1:0] count,
    output logic step
);
    logic [1:0] prev;
    logic [1:0] cur;

    assign cur = {phase_a, phase_b};

    // gray sequence 00-01-11-10 counts up, the reverse counts down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 2'h0;
            count <= '0;
            step <= 1'b0;
        end else if (ce) begin
            prev <= cur;
            step <= 1'b0;
            if (en && cur != prev) begin
                if (cur == {prev[0], ~prev[1]}) begin
                    count <= count + 1'b1;
                    step <= 1'b1;
                end else if (cur == {~prev[0], prev[1]}) begin
                    count <= count - 1'b1;
                    step <= 1'b1;
                end
            end
        end
    end
endmodule : kpd_encoder

// [verilog/kpd_scanner.sv]
// keypad matrix scanner top: apb registers, scan engine, direct keys, encoders
// Summary of operation
// - scans up to 8 returns by 6 columns, direct keys and two encoders
// - matrix and direct inputs are serviced at the same time
// - key interrupts only after activity holds stable beyond the debounce interval; encoder steps flag at once
// - in manual scan software drives columns and reads live returns
// - ignore-multiple policy gives one interrupt for the first debounced press
// - automatic scan walks the columns and stores each row reading
// - scan-on-activity starts a scan and interrupts when it completes
// - software-started automatic scan raises no interrupt
// - eight matrix return inputs are sampled
// - direct inputs 3:2 are keys or encoder B phases
// - direct inputs are used only when software selects them
`timescale 1ns/100ps
module kpd_scanner #(
    parameter int SETTLE_CYC = kpd_pkg::SETTLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [kpd_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [kpd_pkg::COLS-1:0] column_scan_out,
    input wire logic [kpd_pkg::ROWS-1:0] row_return_in,
    input wire logic [kpd_pkg::DKEYS-1:0] direct_key_in,
    output logic irq
);
    // returns reach the result two sync flops late, so fewer than three settle cycles read stale rows
    if (SETTLE_CYC < 3 || SETTLE_CYC > 65535) begin : g_check
        $error("settle count out of range");
    end

    logic [kpd_pkg::ROWS-1:0] rows_s1;
    logic [kpd_pkg::ROWS-1:0] rows_s2;
    logic [kpd_pkg::DKEYS-1:0] dk_s1;
    logic [kpd_pkg::DKEYS-1:0] dk_s2;
    logic [kpd_pkg::CTRL_W-1:0] ctrl;
    logic [kpd_pkg::DEB_CNT_W-1:0] deb_limit;
    logic [kpd_pkg::ST_W-1:0] status;
    logic [kpd_pkg::ST_W-1:0] mask;
    logic [kpd_pkg::ST_W-1:0] st_set;
    logic [kpd_pkg::ST_W-1:0] st_clr;
    logic [kpd_pkg::ST_W-1:0] next_status;
    logic [31:0] next_rdata;
    logic next_err;
    logic wr;
    logic auto_go;
    logic [kpd_pkg::DKEYS-1:0] dk_keys;
    logic [1:0] enc_en;
    logic [1:0] enc_step;
    logic [kpd_pkg::ENC_W-1:0] enc_cnt [2];
    logic [kpd_pkg::ROWS-1:0] scan_res [kpd_pkg::COLS];
    logic [kpd_pkg::ROWS-1:0] rows_rose;
    logic [kpd_pkg::ROWS-1:0] rows_held;
    logic matrix_evt;
    logic direct_evt;
    logic start_act;
    logic start_sw;
    logic from_act;
    logic scan_done;
    logic col_last;
    logic settle_end;
    logic [2:0] col;
    logic [15:0] settle;
    logic [kpd_pkg::COLS-1:0] next_cols;
    kpd_pkg::kpd_scan_state_t state;
    kpd_pkg::kpd_scan_state_t next_state;

    kpd_deb_if deb ();

    // pin inputs pass two flops before any logic looks at them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rows_s1 <= '0;
            rows_s2 <= '0;
            dk_s1 <= '0;
            dk_s2 <= '0;
        end else if (pce) begin
            rows_s1 <= row_return_in;
            rows_s2 <= rows_s1;
            dk_s1 <= direct_key_in;
            dk_s2 <= dk_s1;
        end
    end

    // encoder pins are withheld from the direct-key path while in use
    always_comb begin
        dk_keys = ctrl[kpd_pkg::CTRL_DIRECT_EN] ? dk_s2 : '0;
        if (ctrl[kpd_pkg::CTRL_ENC_A_EN]) begin
            dk_keys[1:0] = 2'h0;
        end
        if (ctrl[kpd_pkg::CTRL_ENC_B_EN]) begin
            dk_keys[3:2] = 2'h0;
        end
    end

    assign enc_en[0] = ctrl[kpd_pkg::CTRL_DIRECT_EN] & ctrl[kpd_pkg::CTRL_ENC_A_EN];
    assign enc_en[1] = ctrl[kpd_pkg::CTRL_DIRECT_EN] & ctrl[kpd_pkg::CTRL_ENC_B_EN];

    for (genvar g = 0; g < 2; g++) begin : g_enc
        kpd_encoder u_enc (
            .pclk(pclk),
            .presetn(presetn),
            .ce(pce),
            .en(enc_en[g]),
            .phase_a(dk_s2[2*g]),
            .phase_b(dk_s2[2*g+1]),
            .count(enc_cnt[g]),
            .step(enc_step[g])
        );
    end

    // one filter serves matrix and direct keys alike
    assign deb.ce = pce;
    assign deb.raw = {dk_keys, rows_s2};
    assign deb.limit = deb_limit;

    kpd_debounce u_deb (
        .pclk(pclk),
        .presetn(presetn),
        .d(deb)
    );

    assign rows_rose = deb.rose[kpd_pkg::ROWS-1:0];
    assign rows_held = deb.stable[kpd_pkg::ROWS-1:0] & ~rows_rose;

    // while the engine walks the columns, returns change on purpose
    always_comb begin
        matrix_evt = 1'b0;
        if (|rows_rose && state == kpd_pkg::st_idle) begin
            if (!ctrl[kpd_pkg::CTRL_IGN_MULTI] || rows_held == '0) begin
                matrix_evt = 1'b1;
            end
        end
    end

    assign direct_evt = |deb.rose[kpd_pkg::DEB_W-1:kpd_pkg::ROWS];

    // apb slave: answer registered in the setup cycle, ready in access
    assign wr = psel & penable & pready & pwrite;
    assign auto_go = wr && paddr == kpd_pkg::OFF_CTRL && pwdata[kpd_pkg::CTRL_AUTO_GO];

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (paddr)
            kpd_pkg::OFF_CTRL: begin
                next_rdata = {20'h0_0000, ctrl};
            end
            kpd_pkg::OFF_DEBOUNCE: begin
                next_rdata = {16'h0000, deb_limit};
            end
            kpd_pkg::OFF_STATUS: begin
                next_rdata = {28'h000_0000, status};
            end
            kpd_pkg::OFF_MASK: begin
                next_rdata = {28'h000_0000, mask};
            end
            kpd_pkg::OFF_LIVE: begin
                next_rdata = {19'h0_0000, state != kpd_pkg::st_idle, deb.stable};
            end
            kpd_pkg::OFF_ENC: begin
                next_rdata = {16'h0000, enc_cnt[1], enc_cnt[0]};
            end
            kpd_pkg::OFF_SCAN_LO: begin
                next_rdata = {scan_res[3], scan_res[2], scan_res[1], scan_res[0]};
            end
            kpd_pkg::OFF_SCAN_HI: begin
                next_rdata = {16'h0000, scan_res[5], scan_res[4]};
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (pce) begin
            pready <= psel & ~penable;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
                pslverr <= next_err;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= kpd_pkg::CTRL_RESET;
            deb_limit <= kpd_pkg::DEB_RESET;
            mask <= '0;
        end else if (pce && wr) begin
            case (paddr)
                kpd_pkg::OFF_CTRL: begin
                    ctrl <= pwdata[kpd_pkg::CTRL_W-1:0];
                end
                kpd_pkg::OFF_DEBOUNCE: begin
                    deb_limit <= pwdata[kpd_pkg::DEB_CNT_W-1:0];
                end
                kpd_pkg::OFF_MASK: begin
                    mask <= pwdata[kpd_pkg::ST_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // scan engine
    assign start_act = matrix_evt & ctrl[kpd_pkg::CTRL_SOA_EN];
    assign start_sw = auto_go & ctrl[kpd_pkg::CTRL_AUTO_EN];
    assign col_last = col == 3'(kpd_pkg::COLS - 1);
    assign settle_end = settle == 16'(SETTLE_CYC - 1);
    assign scan_done = state == kpd_pkg::st_done;

    always_comb begin
        next_state = state;
        case (state)
            kpd_pkg::st_idle: begin
                if (start_act || start_sw) begin
                    next_state = kpd_pkg::st_drive;
                end
            end
            kpd_pkg::st_drive: begin
                if (settle_end && col_last) begin
                    next_state = kpd_pkg::st_done;
                end
            end
            kpd_pkg::st_done: begin
                next_state = kpd_pkg::st_idle;
            end
            default: begin
                next_state = kpd_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= kpd_pkg::st_idle;
        end else if (pce) begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col <= 3'h0;
            settle <= 16'h0000;
            from_act <= 1'b0;
        end else if (pce) begin
            if (state == kpd_pkg::st_idle) begin
                col <= 3'h0;
                settle <= 16'h0000;
                if (start_act || start_sw) begin
                    from_act <= start_act;
                end
            end else if (state == kpd_pkg::st_drive) begin
                if (settle_end) begin
                    settle <= 16'h0000;
                    col <= col + 3'h1;
                end else begin
                    settle <= settle + 16'h0001;
                end
            end
        end
    end

    // each column keeps the returns it saw at the end of its settle time
    for (genvar c = 0; c < kpd_pkg::COLS; c++) begin : g_res
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                scan_res[c] <= '0;
            end else if (pce && state == kpd_pkg::st_drive && settle_end && col == 3'(c)) begin
                scan_res[c] <= rows_s2;
            end
        end
    end

    always_comb begin
        next_cols = ctrl[kpd_pkg::CTRL_MS_LSB +: kpd_pkg::COLS];
        if (next_state == kpd_pkg::st_drive) begin
            next_cols = '0;
            if (state == kpd_pkg::st_idle) begin
                next_cols[0] = 1'b1;
            end else if (settle_end) begin
                next_cols[3'(col + 3'h1)] = 1'b1;
            end else begin
                next_cols[col] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            column_scan_out <= '0;
        end else if (pce) begin
            column_scan_out <= next_cols;
        end
    end

    // status: a new event wins over a clear in the same cycle
    always_comb begin
        st_set = '0;
        st_set[kpd_pkg::ST_MATRIX] = matrix_evt;
        st_set[kpd_pkg::ST_DIRECT] = direct_evt;
        st_set[kpd_pkg::ST_SCAN] = scan_done & from_act;
        st_set[kpd_pkg::ST_ENC] = |enc_step;
        st_clr = (wr && paddr == kpd_pkg::OFF_STATUS) ? pwdata[kpd_pkg::ST_W-1:0] : '0;
        next_status = (status & ~st_clr) | st_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
            irq <= 1'b0;
        end else if (pce) begin
            status <= next_status;
            irq <= |(status & mask);
        end
    end
endmodule : kpd_scanner

// [verification/kpd_scanner_chk.sv]
// port-level assertions for the keypad matrix scanner
`timescale 1ns/100ps
module kpd_scanner_chk #(
    parameter int SETTLE_CYC = kpd_pkg::SETTLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [kpd_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [kpd_pkg::COLS-1:0] column_scan_out,
    input wire logic [kpd_pkg::ROWS-1:0] row_return_in,
    input wire logic [kpd_pkg::DKEYS-1:0] direct_key_in,
    input wire logic irq
);
    logic acc;
    logic unmapped;
    logic ctrl_wr;
    logic stat_wr;
    logic [5:0] last_cols;
    logic [15:0] run;
    logic [11:0] ctrl_q;
    assign acc = psel && penable && pready;
    assign unmapped = paddr > 8'h1c || paddr[1:0] != 2'b00;
    assign ctrl_wr = acc && pwrite && paddr == kpd_pkg::OFF_CTRL;
    assign stat_wr = acc && pwrite && (paddr == kpd_pkg::OFF_STATUS || paddr == kpd_pkg::OFF_MASK);
    // run counts how many samples the column value has held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_cols <= 6'h00;
            run <= 16'h0000;
        end else begin
            last_cols <= column_scan_out;
            run <= (column_scan_out != last_cols) ? 16'h0001 : run + 16'h0001;
        end
    end
    // shadow of the control word, so scan starts can be predicted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 12'h000;
        end else if (ctrl_wr) begin
            ctrl_q <= pwdata[11:0];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable && pce;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    // column steps of the engine, manual writes excluded
    sequence s_col_step;
        $changed(column_scan_out) && $onehot($past(column_scan_out)) && !$past(ctrl_wr) && !$past(ctrl_wr, 2)
            && !$past(ctrl_wr, 3);
    endsequence
    a_ready_first: assert property (s_setup ##1 s_access |-> pready)
        else $error("pready missing in access cycle");
    a_ready_setup: assert property (s_setup |-> !pready)
        else $error("pready high in setup cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_map: assert property (acc |-> pslverr == unmapped)
        else $error("pslverr does not match address map");
    a_err_zero: assert property (acc && !pwrite && unmapped |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    a_irq_drop: assert property ($fell(irq) |-> $past(stat_wr) || $past(stat_wr, 2) || $past(stat_wr, 3))
        else $error("irq fell without status or mask write");
    a_manual_follow: assert property (ctrl_wr && pwdata[7:6] == 2'b00 && ctrl_q[7:6] == 2'b00
        |-> ##2 column_scan_out == $past(pwdata[5:0], 2))
        else $error("columns do not follow manual bits");
    a_scan_start: assert property (ctrl_wr && pwdata[12] && ctrl_q[6] && !$onehot(column_scan_out)
        |-> ##[1:3] column_scan_out == 6'h01)
        else $error("software scan did not start at column zero");
    a_scan_hold: assert property (s_col_step |-> run == SETTLE_CYC)
        else $error("column held for wrong count");
    a_scan_order: assert property (s_col_step and !$past(column_scan_out[5])
        |-> column_scan_out == {$past(column_scan_out[4:0]), 1'b0})
        else $error("columns out of order");
endmodule : kpd_scanner_chk

bind kpd_scanner kpd_scanner_chk #(.SETTLE_CYC(SETTLE_CYC)) i_kpd_scanner_chk (.pclk(pclk), .presetn(presetn),
    .pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .column_scan_out(column_scan_out), .row_return_in(row_return_in),
    .direct_key_in(direct_key_in), .irq(irq));

// [verification/kpd_keypad_model.sv]
// passive key matrix: a pressed key joins its column drive to its row
`timescale 1ns/100ps
module kpd_keypad_model (
    input wire logic [5:0] column_scan_out,
    input wire logic [47:0] keys,
    output logic [7:0] row_return_in
);
    // rows have pull-downs, so an undriven column reads zero
    always_comb begin
        row_return_in = 8'h00;
        for (int c = 0; c < 6; c++) begin
            if (column_scan_out[c]) begin
                row_return_in = row_return_in | keys[c*8 +: 8];
            end
        end
    end
endmodule : kpd_keypad_model

// [verification/kpd_scanner_tb.sv]
// self-checking bench for the keypad matrix scanner
`timescale 1ns/100ps
module kpd_scanner_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] cols;
    logic [7:0] rows;
    logic [3:0] dk = 4'h0;
    logic irq;
    logic [47:0] keys = 48'h0;
    logic [32:0] exp_q[$];
    // phase a sits on the even pin, so the pin pair reads {b, a}
    logic [1:0] gray [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
    logic [31:0] rng = 32'd89;
    int fail_count = 0;
    int num_checks = 0;
    always #4 pclk = ~pclk;
    kpd_scanner #(.SETTLE_CYC(3)) i_kpd_scanner (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .column_scan_out(cols), .row_return_in(rows), .direct_key_in(dk), .irq(irq));
    kpd_keypad_model i_kpd_keypad_model (.column_scan_out(cols), .keys(keys), .row_return_in(rows));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    // request held from setup until pready is seen high
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back({a > 8'h1c || a[1:0] != 2'b00, e});
        bus(a, 1'b0, 32'h0);
    endtask : rd
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                check("stray read", 33'h0, 33'h1);
            end else begin
                check($sformatf("read %h", paddr), {pslverr, prdata}, exp_q.pop_front());
            end
        end
    end
    initial begin
        wt(20000);
        fail_count++;
        $display("watchdog expired");
        end_of_test();
    end
    initial begin
        wt(6);
        presetn <= 1'b1;
        rd(kpd_pkg::OFF_CTRL, 32'h0);
        rd(kpd_pkg::OFF_DEBOUNCE, 32'hff);
        rd(kpd_pkg::OFF_SCAN_HI, 32'h0);
        rng = xs(rng);
        wr(kpd_pkg::OFF_MASK, rng);
        rd(kpd_pkg::OFF_MASK, {28'h0, rng[3:0]});
        wr(kpd_pkg::OFF_DEBOUNCE, 32'h4);
        rd(kpd_pkg::OFF_DEBOUNCE, 32'h4);
        wr(8'h22, 32'h1);
        rd(8'h22, 32'h0);
        wr(kpd_pkg::OFF_LIVE, 32'hffff);
        rd(kpd_pkg::OFF_LIVE, 32'h0);
        $display("register test done");
        rng = xs(rng);
        keys <= {rng[15:0], xs(rng)};
        for (int c = 0; c < 6; c++) begin
            wr(kpd_pkg::OFF_CTRL, 32'h1 << c);
            wt(14);
            rd(kpd_pkg::OFF_LIVE, {24'h0, keys[c*8 +: 8]});
        end
        $display("manual scan test done");
        keys <= 48'h0;
        wr(kpd_pkg::OFF_CTRL, 32'h3f);
        wr(kpd_pkg::OFF_MASK, 32'h1);
        wt(14);
        wr(kpd_pkg::OFF_STATUS, 32'hf);
        // a press shorter than the debounce interval must stay silent
        keys <= 48'h1;
        wt(2);
        keys <= 48'h0;
        wt(14);
        rd(kpd_pkg::OFF_STATUS, 32'h0);
        keys <= 48'h1;
        wt(14);
        rd(kpd_pkg::OFF_STATUS, 32'h1);
        check("irq", {32'h0, irq}, 33'h1);
        wr(kpd_pkg::OFF_MASK, 32'h0);
        wt(2);
        check("irq", {32'h0, irq}, 33'h0);
        wr(kpd_pkg::OFF_STATUS, 32'h1);
        rd(kpd_pkg::OFF_STATUS, 32'h0);
        $display("debounce test done");
        wr(kpd_pkg::OFF_CTRL, 32'h13f);
        keys <= 48'h3;
        wt(14);
        rd(kpd_pkg::OFF_STATUS, 32'h0);
        wr(kpd_pkg::OFF_CTRL, 32'h3f);
        keys <= 48'h7;
        wt(14);
        rd(kpd_pkg::OFF_STATUS, 32'h1);
        $display("multiple press test done");
        keys <= 48'h0;
        wr(kpd_pkg::OFF_CTRL, 32'h40);
        wt(14);
        wr(kpd_pkg::OFF_STATUS, 32'hf);
        rng = xs(rng);
        keys <= {rng[15:0], xs(rng)};
        wr(kpd_pkg::OFF_CTRL, 32'h1040);
        wt(30);
        rd(kpd_pkg::OFF_SCAN_LO, keys[31:0]);
        rd(kpd_pkg::OFF_SCAN_HI, {16'h0, keys[47:32]});
        rd(kpd_pkg::OFF_STATUS, 32'h0);
        $display("software scan test done");
        // same byte on every column keeps the returns steady while scanning
        keys <= 48'h0;
        wr(kpd_pkg::OFF_CTRL, 32'hff);
        wt(14);
        wr(kpd_pkg::OFF_STATUS, 32'hf);
        rng = xs(rng);
        keys <= {6{rng[7:0] | 8'h01}};
        wt(50);
        rd(kpd_pkg::OFF_SCAN_HI, {16'h0, keys[47:32]});
        rd(kpd_pkg::OFF_STATUS, 32'h5);
        $display("activity scan test done");
        wr(kpd_pkg::OFF_CTRL, 32'h3f);
        keys <= 48'h1;
        dk <= 4'hf;
        wt(14);
        wr(kpd_pkg::OFF_STATUS, 32'hf);
        rd(kpd_pkg::OFF_LIVE, 32'h1);
        wr(kpd_pkg::OFF_CTRL, 32'h23f);
        wt(14);
        rd(kpd_pkg::OFF_LIVE, 32'hf01);
        rd(kpd_pkg::OFF_STATUS, 32'h2);
        dk <= 4'h0;
        wt(14);
        wr(kpd_pkg::OFF_CTRL, 32'he3f);
        foreach (gray[i]) begin
            dk[1:0] <= gray[i];
            wt(14);
        end
        dk[3:2] <= 2'b01;
        wt(14);
        rd(kpd_pkg::OFF_ENC, 32'hff04);
        rd(kpd_pkg::OFF_LIVE, 32'h1);
        rd(kpd_pkg::OFF_STATUS, 32'ha);
        $display("direct key and encoder test done");
        // a low clock enable must hold the synced returns where they were
        pce <= 1'b0;
        keys <= 48'h0;
        wt(20);
        pce <= 1'b1;
        rd(kpd_pkg::OFF_LIVE, 32'h1);
        wt(14);
        rd(kpd_pkg::OFF_LIVE, 32'h0);
        $display("clock enable test done");
        end_of_test();
    end
endmodule : kpd_scanner_tb
